// ===== spm_spi_port.sv
// SPI master/slave port with AXI4-Lite register access
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module spm_spi_port
	import spm_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        global_irq_enable,
	input  wire logic        irq_vector_ack,
	output logic             spi_irq,
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe,
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe,
	input  wire logic        ss_n_in,
	output logic             ss_n_out,
	output logic             ss_n_oe
);

	typedef struct packed {
		logic [7:0]             ctrl;
		logic                   done;
		logic                   coll;
		logic                   dbl;
		logic [SPM_DIR_W-1:0]   dir;
		logic                   arm_done;
		logic                   arm_coll;
		logic [7:0]             tx;
		logic [7:0]             rx;
		logic [7:0]             rxbuf;
		logic [2:0]             bitcnt;
		spm_mstate_t            mst;
		logic [6:0]             div_cnt;
		logic [3:0]             edge_cnt;
		logic [1:0]             msamp;
		logic                   sck1;
		logic                   sck2;
		logic                   sck3;
		logic                   ss1;
		logic                   ss2;
		logic                   mosi1;
		logic                   mosi2;
		logic                   miso1;
		logic                   miso2;
		logic                   sck_o;
		logic                   sck_oe;
		logic                   sdo;
		logic                   mosi_oe;
		logic                   miso_oe;
		logic                   ss_o;
		logic                   ss_oe;
		logic                   irq;
		logic                   awready;
		logic                   wready;
		logic                   aw_have;
		logic [7:0]             aw_addr;
		logic                   w_have;
		logic [7:0]             wdata;
		logic                   wlane0;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [7:0]             rdata;
		logic [1:0]             rresp;
	} spm_state_t;

	spm_state_t s;
	spm_state_t next_s;

	// Decoded events, also watched by the assertions
	logic wr_fire;
	logic rd_fire;
	logic data_wr;
	logic data_acc;
	logic busy;
	logic fault;
	logic tick;
	logic samp_edge;

	function automatic logic out_bit(input logic [7:0] v,
		input logic lsb_first);
		out_bit = lsb_first ? v[0] : v[7];
	endfunction

	function automatic logic [7:0] shift_out(input logic [7:0] v,
		input logic lsb_first);
		shift_out = lsb_first ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] v,
		input logic b, input logic lsb_first);
		shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
	endfunction

	// Half an SCK period in system clocks
	function automatic logic [6:0] half_period(input logic [1:0] r,
		input logic dbl);
		logic [7:0] d;
		d = SPM_DIV_N0;
		case ({dbl, r})
			3'h0: d = SPM_DIV_N0;
			3'h1: d = SPM_DIV_N1;
			3'h2: d = SPM_DIV_N2;
			3'h3: d = SPM_DIV_N3;
			3'h4: d = SPM_DIV_D0;
			3'h5: d = SPM_DIV_D1;
			3'h6: d = SPM_DIV_D2;
			default: d = SPM_DIV_D3;
		endcase
		half_period = d[7:1];
	endfunction

	// Whole next state in one place; clears first, sets last so sets win
	always_comb begin
		logic en;
		logic master_select;
		logic lsb;
		logic clock_phase_sel;
		logic leading;
		logic rx_take;
		logic rx_val;
		logic setup;
		logic set_done;
		logic set_coll;
		logic [7:0] nrx;
		en = s.ctrl[SPM_CTL_PORT_EN];
		master_select = s.ctrl[SPM_CTL_MASTER];
		lsb = s.ctrl[SPM_CTL_BIT_ORDER];
		clock_phase_sel = s.ctrl[SPM_CTL_PHASE];
		leading = 1'b0;
		rx_take = 1'b0;
		rx_val = 1'b0;
		setup = 1'b0;
		set_done = 1'b0;
		set_coll = 1'b0;
		nrx = SPM_BYTE_ZERO;
		samp_edge = 1'b0;
		tick = 1'b0;
		next_s = s;
		// Two-stage synchronisers for the pins
		next_s.sck1 = sck_in;
		next_s.sck2 = s.sck1;
		next_s.sck3 = s.sck2;
		next_s.ss1 = ss_n_in;
		next_s.ss2 = s.ss1;
		next_s.mosi1 = mosi_in;
		next_s.mosi2 = s.mosi1;
		next_s.miso1 = miso_in;
		next_s.miso2 = s.miso1;
		next_s.msamp = {s.msamp[0], 1'b0};

		// AXI address and data are taken independently
		if (s.awready && s_axi_awvalid) begin
			next_s.aw_have = 1'b1;
			next_s.aw_addr = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s.wready && s_axi_wvalid) begin
			next_s.w_have = 1'b1;
			next_s.wdata = s_axi_wdata[7:0];
			next_s.wlane0 = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		wr_fire = s.aw_have && s.w_have && !s.bvalid;
		rd_fire = s.arready && s_axi_arvalid;
		busy = (s.mst != SPM_M_IDLE) || (s.bitcnt != 3'h0);
		data_wr = wr_fire && s.wlane0 && (s.aw_addr == SPM_OFF_DATA);
		data_acc = data_wr || (rd_fire
			&& ({s_axi_araddr[7:2], 2'b00} == SPM_OFF_DATA));

		// Flag clearing by access sequence or vector
		if (irq_vector_ack)
			next_s.done = 1'b0;
		if (data_acc) begin
			if (s.arm_done || s.arm_coll)
				next_s.done = 1'b0;
			if (s.arm_coll)
				next_s.coll = 1'b0;
			next_s.arm_done = 1'b0;
			next_s.arm_coll = 1'b0;
		end

		// Register reads; only lane 0 carries data
		if (rd_fire) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = SPM_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				SPM_OFF_CONTROL: next_s.rdata = s.ctrl;
				SPM_OFF_STATUS: begin
					next_s.rdata = {s.done, s.coll, 5'h00, s.dbl};
					if (s.done)
						next_s.arm_done = 1'b1;
					if (s.coll)
						next_s.arm_coll = 1'b1;
				end
				SPM_OFF_DATA: next_s.rdata = s.rxbuf;
				SPM_OFF_DIR: next_s.rdata = {3'h0, s.dir};
				default: begin
					next_s.rdata = SPM_BYTE_ZERO;
					next_s.rresp = SPM_RESP_SLVERR;
				end
			endcase
		end

		// Register writes
		if (wr_fire) begin
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = SPM_RESP_OKAY;
			case (s.aw_addr)
				SPM_OFF_CONTROL:
					if (s.wlane0)
						next_s.ctrl = s.wdata;
				SPM_OFF_STATUS:
					if (s.wlane0)
						next_s.dbl = s.wdata[SPM_STS_DOUBLE];
				SPM_OFF_DATA: ;
				SPM_OFF_DIR:
					if (s.wlane0)
						next_s.dir = s.wdata[SPM_DIR_W-1:0];
				default: next_s.bresp = SPM_RESP_SLVERR;
			endcase
		end

		// Data write: collision while busy, otherwise load, and start when enabled as master
		if (data_wr) begin
			if (busy)
				set_coll = 1'b1;
			else begin
				next_s.tx = s.wdata;
				next_s.sdo = out_bit(s.wdata, lsb);
				if (en && master_select) begin
					next_s.mst = SPM_M_RUN;
					next_s.div_cnt = 7'h00;
					next_s.edge_cnt = 4'h0;
					next_s.bitcnt = 3'h0;
				end
			end
		end

		// Master clock generator: sixteen edges make eight bits
		case (s.mst)
			SPM_M_IDLE: next_s.sck_o = s.ctrl[SPM_CTL_POLARITY];
			SPM_M_RUN: begin
				if (s.div_cnt == half_period(
					s.ctrl[SPM_CTL_RATE_HI:SPM_CTL_RATE_LO], s.dbl) - 7'h01)
				begin
					tick = 1'b1;
					next_s.div_cnt = 7'h00;
					next_s.sck_o = !s.sck_o;
					next_s.edge_cnt = s.edge_cnt + 4'h1;
					leading = !s.edge_cnt[0];
					if (leading ^ clock_phase_sel)
						next_s.msamp[0] = 1'b1;
					else
						setup = 1'b1;
					if (s.edge_cnt == SPM_LAST_EDGE)
						next_s.mst = SPM_M_WAIT;
				end else
					next_s.div_cnt = s.div_cnt + 7'h01;
			end
			SPM_M_WAIT:
				if (s.msamp == 2'h0)
					next_s.mst = SPM_M_IDLE;
			default: next_s.mst = SPM_M_IDLE;
		endcase
		// Miso is two clocks late through the synchroniser, so the
		// master samples it two clocks after its own sampling edge
		if (s.msamp[1]) begin
			rx_take = 1'b1;
			rx_val = s.miso2;
		end

		// Slave side works on the synchronised SCK edges
		if (en && !master_select) begin
			if (s.ss2) begin
				next_s.bitcnt = 3'h0;
				next_s.rx = SPM_BYTE_ZERO;
				if (!data_wr)
					next_s.sdo = out_bit(s.tx, lsb);
			end else if (s.sck2 != s.sck3) begin
				leading = (s.sck2 != s.ctrl[SPM_CTL_POLARITY]);
				if (leading ^ clock_phase_sel) begin
					rx_take = 1'b1;
					rx_val = s.mosi2;
				end else
					setup = 1'b1;
			end
		end

		// Shared shifter: setup drives the next bit out
		if (setup) begin
			if (clock_phase_sel) begin
				next_s.sdo = out_bit(s.tx, lsb);
				next_s.tx = shift_out(s.tx, lsb);
			end else begin
				next_s.tx = shift_out(s.tx, lsb);
				next_s.sdo = out_bit(shift_out(s.tx, lsb), lsb);
			end
		end
		if (rx_take) begin
			samp_edge = 1'b1;
			nrx = shift_in(s.rx, rx_val, lsb);
			next_s.rx = nrx;
			if (s.bitcnt == SPM_LAST_BIT) begin
				next_s.rxbuf = nrx;
				next_s.bitcnt = 3'h0;
				set_done = 1'b1;
			end else
				next_s.bitcnt = s.bitcnt + 3'h1;
		end

		// Mode fault: another master pulled slave select low
		fault = en && master_select && !s.dir[SPM_DIR_SS] && !s.ss2;
		if (fault) begin
			next_s.ctrl[SPM_CTL_MASTER] = 1'b0;
			set_done = 1'b1;
			next_s.mst = SPM_M_IDLE;
			next_s.bitcnt = 3'h0;
			next_s.msamp = 2'h0;
		end
		// Disabled port abandons any transfer
		if (!en) begin
			next_s.mst = SPM_M_IDLE;
			next_s.bitcnt = 3'h0;
			next_s.msamp = 2'h0;
		end

		if (set_done)
			next_s.done = 1'b1;
		if (set_coll)
			next_s.coll = 1'b1;

		// Pin drive follows the settled control state
		next_s.sck_oe = next_s.ctrl[SPM_CTL_PORT_EN]
			&& next_s.ctrl[SPM_CTL_MASTER] && next_s.dir[SPM_DIR_SCK];
		next_s.mosi_oe = next_s.ctrl[SPM_CTL_PORT_EN]
			&& next_s.ctrl[SPM_CTL_MASTER] && next_s.dir[SPM_DIR_MOSI];
		next_s.miso_oe = next_s.ctrl[SPM_CTL_PORT_EN]
			&& !next_s.ctrl[SPM_CTL_MASTER] && !s.ss2
			&& next_s.dir[SPM_DIR_MISO];
		next_s.ss_oe = next_s.ctrl[SPM_CTL_PORT_EN]
			&& next_s.ctrl[SPM_CTL_MASTER] && next_s.dir[SPM_DIR_SS];
		next_s.ss_o = next_s.dir[SPM_DIR_SS_VAL];
		next_s.irq = next_s.done && global_irq_enable
			&& next_s.ctrl[SPM_CTL_IRQ_ENABLE];
		next_s.awready = !next_s.aw_have && !next_s.bvalid;
		next_s.wready = !next_s.w_have && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;
	end

	// State register; reset leaves a disabled slave in mode 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.ctrl <= SPM_CONTROL_RST;
			s.mst <= SPM_M_IDLE;
		end else
			s <= next_s;
	end

	// Ports come straight from the state flops
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = {SPM_PAD_ZERO, s.rdata};
	assign s_axi_rresp = s.rresp;
	assign spi_irq = s.irq;
	assign sck_out = s.sck_o;
	assign sck_oe = s.sck_oe;
	assign mosi_out = s.sdo;
	assign mosi_oe = s.mosi_oe;
	assign miso_out = s.sdo;
	assign miso_oe = s.miso_oe;
	assign ss_n_out = s.ss_o;
	assign ss_n_oe = s.ss_oe;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_irq_request: assert property (
		(s.done && s.ctrl[SPM_CTL_IRQ_ENABLE] && global_irq_enable
			&& !irq_vector_ack && !data_acc && !wr_fire) |=> spi_irq)
		else $error("interrupt request missing");
	a_disabled_quiet: assert property (
		!s.ctrl[SPM_CTL_PORT_EN] |=> (s.mst == SPM_M_IDLE
			&& (!s.sck_oe || s.ctrl[SPM_CTL_PORT_EN])))
		else $error("transfer logic active while disabled");
	a_mode_fault: assert property (
		fault |=> (!s.ctrl[SPM_CTL_MASTER] && s.done && !mosi_oe
			&& !sck_oe))
		else $error("mode fault not handled");
	a_slave_reset: assert property (
		(s.ctrl[SPM_CTL_PORT_EN] && !s.ctrl[SPM_CTL_MASTER] && s.ss2)
			|=> (s.bitcnt == 3'h0))
		else $error("slave shifter not reset by select");
	a_collision: assert property (
		(data_wr && busy && !tick) |=> (s.coll && $stable(s.tx)))
		else $error("write collision not flagged");
	a_start_run: assert property (
		(data_wr && !busy && s.ctrl[SPM_CTL_PORT_EN]
			&& s.ctrl[SPM_CTL_MASTER] && !fault)
			|=> (s.mst == SPM_M_RUN && s.tx == $past(s.wdata)))
		else $error("data write did not start master");
	a_eight_bits: assert property (
		(tick && s.edge_cnt == SPM_LAST_EDGE)
			|=> (s.mst == SPM_M_WAIT
			&& sck_out == s.ctrl[SPM_CTL_POLARITY]) ##[1:3]
			(s.mst == SPM_M_IDLE))
		else $error("master did not stop after eight bits");
	a_sck_rate: assert property (
		(s.mst == SPM_M_RUN && $changed(sck_out) && $past(s.mst)
			== SPM_M_RUN) |-> ($past(s.div_cnt) == half_period(
			$past(s.ctrl[SPM_CTL_RATE_HI:SPM_CTL_RATE_LO]),
			$past(s.dbl)) - 7'h01))
		else $error("SCK edge at wrong divider count");
	a_byte_done: assert property (
		(samp_edge && s.bitcnt == SPM_LAST_BIT)
			|=> (s.done && s.rxbuf == s.rx))
		else $error("finished byte not flagged");
	a_miso_drive: assert property (
		miso_oe |-> (!s.ctrl[SPM_CTL_MASTER] && s.dir[SPM_DIR_MISO]))
		else $error("MISO driven outside selected slave");
	a_flag_clear: assert property (
		(data_acc && s.arm_coll && !fault && !samp_edge && !data_wr)
			|=> (!s.coll && !s.done))
		else $error("status-then-data did not clear flags");

	c_master_byte: cover property (
		(tick && s.edge_cnt == SPM_LAST_EDGE) ##[1:3] s.done);
	c_slave_byte: cover property (
		samp_edge && !s.ctrl[SPM_CTL_MASTER]
		&& s.bitcnt == SPM_LAST_BIT);
	c_mode_fault: cover property (fault);
	c_collision: cover property (data_wr && busy);

endmodule
`default_nettype wire

// ===== spm_pkg.sv
// Constants and types shared by the SPI master/slave port
package spm_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] SPM_OFF_CONTROL = 8'h00;
	localparam logic [7:0] SPM_OFF_STATUS  = 8'h04;
	localparam logic [7:0] SPM_OFF_DATA    = 8'h08;
	localparam logic [7:0] SPM_OFF_DIR     = 8'h0C;
	// Control register fields
	localparam int SPM_CTL_IRQ_ENABLE = 7;
	localparam int SPM_CTL_PORT_EN    = 6;
	localparam int SPM_CTL_BIT_ORDER  = 5;
	localparam int SPM_CTL_MASTER     = 4;
	localparam int SPM_CTL_POLARITY   = 3;
	localparam int SPM_CTL_PHASE      = 2;
	localparam int SPM_CTL_RATE_HI    = 1;
	localparam int SPM_CTL_RATE_LO    = 0;
	// Status register fields
	localparam int SPM_STS_DONE      = 7;
	localparam int SPM_STS_COLLISION = 6;
	localparam int SPM_STS_DOUBLE    = 0;
	// Pin direction register fields
	localparam int SPM_DIR_MOSI   = 0;
	localparam int SPM_DIR_MISO   = 1;
	localparam int SPM_DIR_SCK    = 2;
	localparam int SPM_DIR_SS     = 3;
	localparam int SPM_DIR_SS_VAL = 4;
	localparam int SPM_DIR_W      = 5;
	// Reset values
	localparam logic [7:0] SPM_CONTROL_RST = 8'h00;
	localparam logic [7:0] SPM_BYTE_ZERO   = 8'h00;
	localparam logic [23:0] SPM_PAD_ZERO   = 24'h000000;
	// SCK divisors of the system clock, normal and double speed
	localparam logic [7:0] SPM_DIV_N0 = 8'h04;
	localparam logic [7:0] SPM_DIV_N1 = 8'h10;
	localparam logic [7:0] SPM_DIV_N2 = 8'h40;
	localparam logic [7:0] SPM_DIV_N3 = 8'h80;
	localparam logic [7:0] SPM_DIV_D0 = 8'h02;
	localparam logic [7:0] SPM_DIV_D1 = 8'h08;
	localparam logic [7:0] SPM_DIV_D2 = 8'h20;
	localparam logic [7:0] SPM_DIV_D3 = 8'h40;
	// Byte framing
	localparam logic [2:0] SPM_LAST_BIT  = 3'h7;
	localparam logic [3:0] SPM_LAST_EDGE = 4'hF;
	// AXI responses
	localparam logic [1:0] SPM_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SPM_RESP_SLVERR = 2'h2;
	// Master clock generator states
	typedef enum logic [2:0] {
		SPM_M_IDLE = 3'h1,
		SPM_M_RUN  = 3'h2,
		SPM_M_WAIT = 3'h4
	} spm_mstate_t;
endpackage

// ===== spm_spi_partner.sv
// Behavioural far-side SPI device: byte responder and external master
`timescale 1ns/1ns
`default_nettype none
module spm_spi_partner (
	input  wire logic       aclk,
	input  wire logic       sck,
	input  wire logic       sdi,
	input  wire logic       pol,
	input  wire logic       pha,
	input  wire logic       lsb,
	input  wire logic [7:0] tx,
	output logic            sdo,
	output logic            p_sck,
	output logic            p_ss_n
);
	logic [7:0] rx = 8'h00;
	logic       busy = 1'b0;
	int         ne = 0;
	int         ns = 0;

	// Idle levels: select held high so a master keeps running
	initial begin
		sdo = 1'b0;
		p_sck = 1'b0;
		p_ss_n = 1'b1;
	end

	// Bit position of the n-th bit on the wire
	function automatic int bix(input int n);
		return lsb ? n : 7 - n;
	endfunction

	// Arm for one byte: first bit is out before any clock edge
	task automatic load();
		ne = 0;
		ns = 0;
		rx = 8'h00;
		sdo = tx[bix(0)];
		busy = 1'b1;
	endtask

	// Undriven line flips so stale data never looks valid
	always @(negedge aclk) begin
		if (!busy)
			sdo = ~sdo;
	end

	// Sample and shift on opposite edges of the serial clock
	always @(posedge sck or negedge sck) begin
		if (busy) begin
			ne++;
			if (sck == !(pol ^ pha) && ns < 8) begin
				rx[bix(ns)] = sdi;
				ns++;
			end else if (sck != !(pol ^ pha) && ns < 8)
				sdo = tx[bix(ns)];
		end
	end

	// Act as outside master for nedge clock edges, half = cycles per edge
	task automatic drive_byte(input int half, input int nedge);
		p_sck <= pol;
		@(posedge aclk);
		load();
		p_ss_n <= 1'b0;
		repeat (nedge) begin
			repeat (half) @(posedge aclk);
			p_sck <= ~p_sck;
		end
		repeat (half) @(posedge aclk);
		p_ss_n <= 1'b1;
		busy = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== spm_spi_port_tb_top.sv
// Self-checking bench for the SPI master/slave port
`timescale 1ns/1ns
`default_nettype none
module spm_spi_port_tb_top
	import spm_pkg::*;
;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        global_irq_enable = 1'b0;
	logic        irq_vector_ack = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
	logic [31:0] s_axi_rdata;
	logic        spi_irq, sck_out, sck_oe, mosi_out, mosi_oe;
	logic        miso_out, miso_oe, ss_n_out, ss_n_oe;
	logic        sck_in, mosi_in, miso_in, ss_n_in, sdo, p_sck, p_ss_n;
	logic        pol = 1'b0, pha = 1'b0, lsb = 1'b0, p_mst = 1'b0;
	logic [7:0]  p_tx = 8'h00, sb;
	int          bad_count = 0;
	int          num_checks = 0;
	int          dv[8] = '{4, 16, 64, 128, 2, 8, 32, 64};

	always #50 aclk = ~aclk;

	// Wire levels: whoever enables its driver owns the line
	assign sck_in = sck_oe ? sck_out : p_sck;
	assign mosi_in = mosi_oe ? mosi_out : sdo;
	assign miso_in = miso_oe ? miso_out : sdo;
	assign ss_n_in = ss_n_oe ? ss_n_out : p_ss_n;

	spm_spi_port i_spm_spi_port (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .global_irq_enable, .irq_vector_ack,
		.spi_irq, .sck_in, .sck_out, .sck_oe, .mosi_in, .mosi_out, .mosi_oe,
		.miso_in, .miso_out, .miso_oe, .ss_n_in, .ss_n_out, .ss_n_oe
	);

	spm_spi_partner i_spm_spi_partner (
		.aclk, .sck(sck_in), .sdi(p_mst ? mosi_in : miso_in), .pol, .pha,
		.lsb, .tx(p_tx), .sdo, .p_sck, .p_ss_n
	);

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string m);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Write: address and data offered together, each held until taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'($urandom), d};
		s_axi_wstrb <= {3'($urandom), 1'b1};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		last_resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Read and compare the low byte, upper lanes must be zero
	task automatic rchk(input logic [7:0] a, input logic [7:0] e,
			input string m);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge aclk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (s_axi_rvalid !== 1'b1);
		last_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, {24'h000000, e}, m);
	endtask

	// One master byte against the responder, optionally with a collision
	task automatic mxfer(input logic [7:0] c, input logic dbl,
			input logic coll);
		logic [7:0] b;
		logic       s;
		logic       ir;
		int         h;
		b = 8'($urandom);
		p_tx = 8'($urandom);
		pol = c[3];
		pha = c[2];
		lsb = c[5];
		wr(SPM_OFF_STATUS, {7'h00, dbl});
		wr(SPM_OFF_CONTROL, c);
		// Idle level follows the new control one clock later
		@(posedge aclk);
		chk(sck_out, pol, "sck idle level");
		chk({ss_n_oe, ss_n_out}, 2'b10, "select pin as output");
		i_spm_spi_partner.load();
		wr(SPM_OFF_DATA, b);
		if (coll)
			wr(SPM_OFF_DATA, ~b);
		s = sck_out;
		while (sck_out === s)
			@(posedge aclk);
		s = sck_out;
		h = 0;
		do begin
			@(posedge aclk);
			h++;
		end while (sck_out === s && h < 99);
		chk(h, dv[{dbl, c[1:0]}] / 2, "sck half period");
		h = 0;
		while (i_spm_spi_partner.ne < 16 && h < 3000) begin
			@(posedge aclk);
			h++;
		end
		repeat (5) @(posedge aclk);
		ir = c[7] & global_irq_enable;
		chk(spi_irq, ir, "interrupt");
		chk(i_spm_spi_partner.ne, 16, "sck edge count");
		chk(i_spm_spi_partner.rx, b, "byte sent");
		if (ir) begin
			irq_vector_ack <= 1'b1;
			@(posedge aclk);
			irq_vector_ack <= 1'b0;
		end
		rchk(SPM_OFF_STATUS, {!ir, coll, 5'h00, dbl}, "flags");
		rchk(SPM_OFF_DATA, p_tx, "byte received");
		rchk(SPM_OFF_STATUS, {7'h00, dbl}, "flags cleared");
		rchk(SPM_OFF_CONTROL, c, "control kept");
		i_spm_spi_partner.busy = 1'b0;
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'h8E97A41C));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int k = 0; k < 4; k++)
			rchk(8'(4 * k), 8'h00, "reset value");
		rchk(8'h10, 8'h00, "unmapped read");
		chk(last_resp, SPM_RESP_SLVERR, "unmapped read resp");
		wr(8'h10, 8'h5A);
		chk(last_resp, SPM_RESP_SLVERR, "unmapped write resp");
		wr(SPM_OFF_STATUS, 8'hFF);
		rchk(SPM_OFF_STATUS, 8'h01, "flags read only");
		// A disabled port must not start a byte
		wr(SPM_OFF_DIR, 8'h0D);
		wr(SPM_OFF_CONTROL, 8'h10);
		wr(SPM_OFF_DATA, 8'hA5);
		repeat (40) @(posedge aclk);
		chk(sck_oe, 1'b0, "no clock when off");
		rchk(SPM_OFF_STATUS, 8'h01, "no flag when off");
		// Every rate, mode, order and interrupt gate; select low as output
		p_mst = 1'b1;
		for (int i = 0; i < 8; i++) begin
			global_irq_enable <= i[0];
			mxfer({i[1], 1'b1, i[0] ^ i[2], 1'b1, i[1:0] ^ {2{i[2]}},
				i[1:0]}, i[2], 1'b0);
		end
		mxfer(8'h53, 1'b0, 1'b1);
		// Select pulled low on an input pin throws the master out
		wr(SPM_OFF_DIR, 8'h05);
		wr(SPM_OFF_CONTROL, 8'h50);
		chk(sck_oe, 1'b1, "master drives sck");
		i_spm_spi_partner.p_ss_n <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(sck_oe | mosi_oe, 1'b0, "pins released");
		rchk(SPM_OFF_CONTROL, 8'h40, "master dropped");
		rchk(SPM_OFF_STATUS, 8'h80, "fault flag");
		rchk(SPM_OFF_DATA, p_tx, "buffer kept");
		rchk(SPM_OFF_STATUS, 8'h00, "fault flag cleared");
		i_spm_spi_partner.p_ss_n <= 1'b1;
		// Slave: a cut-short frame is dropped, a whole one lands
		p_mst = 1'b0;
		pha = 1'b1;
		lsb = 1'b1;
		wr(SPM_OFF_DIR, 8'h02);
		wr(SPM_OFF_CONTROL, 8'h64);
		p_tx = 8'($urandom);
		i_spm_spi_partner.drive_byte(8, 6);
		// Select rise reaches the pin driver through the synchroniser
		repeat (4) @(posedge aclk);
		chk(miso_oe, 1'b0, "miso off when deselected");
		rchk(SPM_OFF_STATUS, 8'h00, "partial byte dropped");
		sb = 8'($urandom);
		wr(SPM_OFF_DATA, sb);
		p_tx = 8'($urandom);
		i_spm_spi_partner.drive_byte(8, 16);
		repeat (4) @(posedge aclk);
		rchk(SPM_OFF_STATUS, 8'h80, "slave done");
		rchk(SPM_OFF_DATA, p_tx, "slave received");
		chk(i_spm_spi_partner.rx, sb, "slave sent");
		end_of_test();
	end

	// Cut a hang short
	initial begin
		repeat (60000) @(posedge aclk);
		bad_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
